// ### elsc_pkg.sv
package elsc_pkg;
    // Register map (byte offsets on the plain register port)
    localparam logic [7:0] ADDR_CTRL1 = 8'hF8;
    localparam logic [7:0] ADDR_CTRL2 = 8'hF9;
    localparam logic [7:0] ADDR_PULLUP_RELEASE = 8'h57;
    localparam logic [7:0] ADDR_STATUS = 8'hFB;
    // Control register 1 fields
    localparam int C1_ENABLE = 0;
    localparam int C1_BUFDIR = 1;
    localparam int C1_FASTMEM = 2;
    localparam int C1_IRQ15_RI = 4;
    localparam int C1_INH_IO = 5;
    localparam int C1_INH_DMA = 6;
    localparam int C1_INH_MEM = 7;
    // Control register 2 fields
    localparam int C2_MODE_LO = 0;
    localparam int C2_MODE_HI = 1;
    localparam int C2_COUNT_LO = 2;
    localparam int C2_COUNT_HI = 4;
    localparam int C2_EOI_LO = 5;
    localparam int C2_EOI_HI = 6;
    localparam int C2_SPK_SYNC = 7;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h04;
    localparam logic [1:0] MODE_NEVER = 2'h0;
    localparam logic [1:0] MODE_HW = 2'h1;
    localparam logic [1:0] MODE_SW = 2'h2;
    localparam logic [2:0] COUNT_ONE = 3'h1;
    // Broadcast cycle length in link clocks
    localparam logic [2:0] BCAST_CLOCKS = 3'h3;
    typedef enum logic [2:0] {SC_IDLE, SC_SEND, SC_HOLD, SC_STOPPED} elsc_stop_type;
endpackage

// ### elsc_ctrl.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Clock halts only after stop-clock broadcast sent
// - Backoff abandons cycle before address latch enable
// - Backoff blocks DMA and EOI until relatched
// - Command pull-up stays until register 57h written
// - Select/backoff function enables its pull-up
// - Link enable takes over I/O, ring pins
// - Master enable off disables all link functions except the command pull-up, which stays on until 57h is written
// - Control bit picks row strobe or direction
// - Link enable moves IDE read to TC
// - Per-type bits suppress strobes on select
// - Assignment bit routes IRQ15 to ring SMI
// - Control bit picks speaker drive style
// - Three-bit stop count sent in broadcast
// - Mode 01 broadcasts on CPU stop grant
// - Mode 01 delays phase 1 until ISA decode
// - Mode 00 drives phase 1 on strobe
// - Writing 10 forces one broadcast, byte ignored
// - Forced mode reverts to previous value once the broadcast starts
module elsc_ctrl
    import elsc_pkg::*;
#(
    parameter int COUNT_W = 3
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic at_bus_clock,
    input wire logic select_backoff_in_n,
    input wire logic stop_grant_n,
    input wire logic cpu_address_strobe_n,
    input wire logic isaDecoded,
    input wire logic cycleMem,
    input wire logic cycleDma,
    input wire logic cycleIo,
    input wire logic cycleStarted,
    input wire logic addrLatchDone,
    input wire logic ringIndicatorPin,
    input wire logic irq15Slot,
    input wire logic drqUpdated,
    input wire logic eoiRequest,
    input wire logic readStrobeInt,
    input wire logic rowStrobeInt,
    input wire logic busDirInt,
    input wire logic generalIoInt,
    input wire logic speakerInt,
    input wire logic speakerSyncSlot,
    output logic linkCmdOut,
    output logic linkCmdPullup,
    output logic selectPullup,
    output logic general_io_one,
    output logic sharedPin78,
    output logic ide_read_strobe_n,
    output logic tcPinReadStrobe,
    output logic aleAllowed,
    output logic commandSuppress,
    output logic abortCycle,
    output logic dmaBlock,
    output logic eoiBlock,
    output logic irq15Out,
    output logic ringSmi,
    output logic speaker_data_out,
    output logic phase1Go,
    output logic [COUNT_W-1:0] stop_clock_count,
    output logic bcastActive,
    output logic atClockEnable
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [1:0] prevMode_r;
    logic pullupOn_r;
    logic [2:0] atSync_r;
    logic [1:0] selSync_r;
    logic [1:0] gntSync_r;
    logic [1:0] adsSync_r;
    logic [1:0] riSync_r;
    logic atRise;
    logic linkOn;
    logic backoff;
    logic grantSeen;
    logic adsSeen;
    logic backoffHeld_r;
    logic swRequest_r;
    logic [2:0] edgeCnt_r;
    logic startDelay_r;
    elsc_stop_type stopState_r;
    logic [1:0] modeNow;

    assign linkOn = ctrl1_r[C1_ENABLE];
    assign modeNow = ctrl2_r[C2_MODE_HI:C2_MODE_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; logic reads only the second stage onward
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            atSync_r <= 3'h0;
            selSync_r <= 2'h3;
            gntSync_r <= 2'h3;
            adsSync_r <= 2'h3;
            riSync_r <= 2'h0;
        end else begin
            atSync_r <= {atSync_r[1:0], at_bus_clock};
            selSync_r <= {selSync_r[0], select_backoff_in_n};
            gntSync_r <= {gntSync_r[0], stop_grant_n};
            adsSync_r <= {adsSync_r[0], cpu_address_strobe_n};
            riSync_r <= {riSync_r[0], ringIndicatorPin};
        end
    end

    assign atRise = atSync_r[1] && !atSync_r[2];
    assign backoff = linkOn && !selSync_r[1];
    assign grantSeen = !gntSync_r[1];
    assign adsSeen = !adsSync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl1_r <= CTRL1_RESET;
            ctrl2_r <= CTRL2_RESET;
            prevMode_r <= MODE_NEVER;
            swRequest_r <= 1'b0;
        end else begin
            if (regWrite && regAddr == ADDR_CTRL1) begin
                ctrl1_r <= regWrData;
            end
            if (regWrite && regAddr == ADDR_CTRL2) begin
                if (regWrData[C2_MODE_HI:C2_MODE_LO] == MODE_SW) begin
                    // Rest of byte ignored: no read-modify-write needed
                    if (linkOn && stopState_r != SC_STOPPED) begin
                        ctrl2_r[C2_MODE_HI:C2_MODE_LO] <= MODE_SW;
                        swRequest_r <= 1'b1;
                    end
                end else if (regWrData[C2_MODE_HI:C2_MODE_LO] != 2'h3) begin
                    ctrl2_r <= regWrData;
                    prevMode_r <= regWrData[C2_MODE_HI:C2_MODE_LO];
                end
            end else if (swRequest_r && stopState_r == SC_SEND) begin
                swRequest_r <= 1'b0;
                ctrl2_r[C2_MODE_HI:C2_MODE_LO] <= prevMode_r;
            end
        end
    end

    // Pull-up on command pin released by any write to 57h
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pullupOn_r <= 1'b1;
        end else if (regWrite && regAddr == ADDR_PULLUP_RELEASE) begin
            pullupOn_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                ADDR_CTRL1: regRdData <= ctrl1_r;
                ADDR_CTRL2: regRdData <= ctrl2_r;
                ADDR_STATUS: regRdData <= {4'h0, backoffHeld_r, bcastActive,
                    stopState_r == SC_STOPPED, pullupOn_r};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stop-clock broadcast sequencer, paced by link clock edges
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !linkOn) begin
            stopState_r <= SC_IDLE;
            edgeCnt_r <= 3'h0;
        end else begin
            case (stopState_r)
                SC_IDLE: begin
                    if (swRequest_r || (modeNow == MODE_HW && grantSeen)) begin
                        stopState_r <= SC_SEND;
                        edgeCnt_r <= BCAST_CLOCKS;
                    end
                end
                SC_SEND: begin
                    if (atRise) begin
                        if (edgeCnt_r == 3'h1) begin
                            stopState_r <= SC_HOLD;
                            edgeCnt_r <= ctrl2_r[C2_COUNT_HI:C2_COUNT_LO];
                        end else begin
                            edgeCnt_r <= edgeCnt_r - 3'h1;
                        end
                    end
                end
                SC_HOLD: begin
                    if (atRise) begin
                        if (edgeCnt_r <= 3'h1) begin
                            stopState_r <= SC_STOPPED;
                        end else begin
                            edgeCnt_r <= edgeCnt_r - 3'h1;
                        end
                    end
                end
                SC_STOPPED: begin
                    // Select low while stopped asks for clock restart
                    if (!selSync_r[1] && !grantSeen) begin
                        stopState_r <= SC_IDLE;
                    end
                end
                default: stopState_r <= SC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Backoff hold: released after DRQ/IRQ relatched or on master disable
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            backoffHeld_r <= 1'b0;
        end else if (backoff) begin
            backoffHeld_r <= 1'b1;
        end else if (!linkOn || drqUpdated) begin
            // Master disable drops a pending hold too
            backoffHeld_r <= 1'b0;
        end
    end

    // Mode 01 adds one link clock before phase 1 starts
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            startDelay_r <= 1'b0;
        end else if (!(adsSeen && isaDecoded)) begin
            startDelay_r <= 1'b0;
        end else if (atRise) begin
            startDelay_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            linkCmdOut <= 1'b1;
            linkCmdPullup <= 1'b1;
            selectPullup <= 1'b0;
            general_io_one <= 1'b0;
            sharedPin78 <= 1'b1;
            ide_read_strobe_n <= 1'b1;
            tcPinReadStrobe <= 1'b0;
            aleAllowed <= 1'b0;
            commandSuppress <= 1'b0;
            abortCycle <= 1'b0;
            dmaBlock <= 1'b0;
            eoiBlock <= 1'b0;
            irq15Out <= 1'b0;
            ringSmi <= 1'b0;
            speaker_data_out <= 1'b0;
            phase1Go <= 1'b0;
            stop_clock_count <= COUNT_W'(COUNT_ONE);
            bcastActive <= 1'b0;
            atClockEnable <= 1'b1;
        end else begin
            linkCmdPullup <= pullupOn_r;
            selectPullup <= linkOn;
            // Pin 173: command when linked, else general I/O
            linkCmdOut <= linkOn ? !(bcastActive || phase1Go) : 1'b1;
            general_io_one <= linkOn ? 1'b0 : generalIoInt;
            sharedPin78 <= (linkOn && ctrl1_r[C1_BUFDIR]) ? busDirInt : rowStrobeInt;
            ide_read_strobe_n <= readStrobeInt;
            tcPinReadStrobe <= linkOn;
            aleAllowed <= linkOn;
            commandSuppress <= !selSync_r[1] && linkOn &&
                ((cycleMem && ctrl1_r[C1_INH_MEM]) || (cycleDma && ctrl1_r[C1_INH_DMA])
                || (cycleIo && ctrl1_r[C1_INH_IO]));
            abortCycle <= backoff && cycleStarted && !addrLatchDone;
            dmaBlock <= backoff || backoffHeld_r;
            eoiBlock <= (backoff || backoffHeld_r) && eoiRequest;
            irq15Out <= (linkOn && ctrl1_r[C1_IRQ15_RI]) ? 1'b0 : irq15Slot;
            ringSmi <= linkOn ? (ctrl1_r[C1_IRQ15_RI] && irq15Slot) : riSync_r[1];
            speaker_data_out <= (linkOn && ctrl2_r[C2_SPK_SYNC]) ?
                (speakerInt && speakerSyncSlot) : speakerInt;
            phase1Go <= linkOn && adsSeen && (modeNow == MODE_HW ?
                (isaDecoded && startDelay_r) : 1'b1);
            stop_clock_count <= ctrl2_r[C2_COUNT_HI:C2_COUNT_LO];
            bcastActive <= stopState_r == SC_SEND;
            atClockEnable <= stopState_r != SC_STOPPED;
        end
    end
endmodule

// ### elsc_ctrl_chk.sv
`timescale 1ns/1ps
module elsc_ctrl_chk
    import elsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic select_backoff_in_n,
    input wire logic irq15Slot,
    input wire logic drqUpdated,
    input wire logic linkCmdPullup,
    input wire logic commandSuppress,
    input wire logic abortCycle,
    input wire logic dmaBlock,
    input wire logic irq15Out,
    input wire logic ringSmi,
    input wire logic bcastActive,
    input wire logic atClockEnable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [7:0] ctl1_r;
    logic sent_r;
    // Shadow of control 1, tracks writes only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) ctl1_r <= CTRL1_RESET;
        else if (regWrite && regAddr == ADDR_CTRL1) ctl1_r <= regWrData;
    end
    // Broadcast seen while the clock has been running
    always_ff @(posedge clk_sys) begin
        if (sys_rst || $rose(atClockEnable)) sent_r <= 1'b0;
        else if (bcastActive) sent_r <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    sequence swReq;
        regWrite && regAddr == ADDR_CTRL2 && regWrData[1:0] == MODE_SW;
    endsequence
    sequence heldLow;
        (!select_backoff_in_n && ctl1_r[C1_ENABLE]) [*6];
    endsequence
    chk_pullup_kept: assert property ($fell(linkCmdPullup) |->
        $past(regWrite, 2) && $past(regAddr, 2) == ADDR_PULLUP_RELEASE)
        else $error("pull-up dropped without release write");
    chk_clock_gate: assert property ($fell(atClockEnable) |-> sent_r)
        else $error("clock gated without broadcast");
    chk_hold_count: assert property ($fell(bcastActive) && atClockEnable |->
        atClockEnable [*4])
        else $error("clock gated right after broadcast");
    chk_sw_force: assert property (swReq ##0 (ctl1_r[C1_ENABLE] && atClockEnable
        && !bcastActive && !sent_r) |-> ##[1:8] bcastActive)
        else $error("forced broadcast missing");
    chk_backoff_dma: assert property (heldLow |-> dmaBlock)
        else $error("dma not blocked on backoff");
    chk_dma_release: assert property ($fell(dmaBlock) && ctl1_r[C1_ENABLE] |->
        $past(drqUpdated) || $past(drqUpdated, 2))
        else $error("dma released before relatch");
    chk_off_quiet: assert property (!ctl1_r[C1_ENABLE] && !$past(ctl1_r[C1_ENABLE])
        && !$past(ctl1_r[C1_ENABLE], 2) |-> !dmaBlock && !bcastActive && !abortCycle
        && !commandSuppress)
        else $error("link activity while disabled");
    chk_ring_route: assert property (ctl1_r[C1_ENABLE] && ctl1_r[C1_IRQ15_RI]
        && $past(ctl1_r[C1_ENABLE]) && $past(ctl1_r[C1_IRQ15_RI]) |->
        ringSmi == $past(irq15Slot) && !irq15Out)
        else $error("irq15 not routed to ring smi");
    chk_suppress_cause: assert property ($rose(commandSuppress) |->
        $past(ctl1_r[C1_INH_MEM]) || $past(ctl1_r[C1_INH_DMA]) || $past(ctl1_r[C1_INH_IO]))
        else $error("strobes hidden with no inhibit bit");
endmodule
bind elsc_ctrl elsc_ctrl_chk u_elsc_ctrl_chk (.clk_sys, .sys_rst, .regAddr, .regWrData,
    .regWrite, .select_backoff_in_n, .irq15Slot, .drqUpdated, .linkCmdPullup,
    .commandSuppress, .abortCycle, .dmaBlock, .irq15Out, .ringSmi, .bcastActive,
    .atClockEnable);

// ### elsc_link_peer.sv
`timescale 1ns/1ps
module elsc_link_peer (
    input wire logic clkRun,
    input wire logic selReq,
    output logic at_bus_clock,
    output logic select_backoff_in_n
);
    initial at_bus_clock = 1'b0;
    // Parks low once the host gates the clock
    always #100 if (clkRun || at_bus_clock) at_bus_clock = ~at_bus_clock;
    // Released line rests at the pull-up level; requests whenever selReq is high, even mid-cycle
    assign select_backoff_in_n = !selReq;
endmodule

// ### elsc_ctrl_bench.sv
`timescale 1ns/1ps
module elsc_ctrl_bench;
    import elsc_pkg::*;
    logic clk_sys = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic stop_grant_n = 1'b1, cpu_address_strobe_n = 1'b1, isaDecoded = 1'b0, aux = 1'b0;
    logic cycleIo = 1'b0, cycleStarted = 1'b0, irq15Slot = 1'b0, drqUpdated = 1'b0;
    logic busDirInt = 1'b0, selReq = 1'b0, at_bus_clock, select_backoff_in_n;
    logic atClockEnable, bcastActive, dmaBlock, abortCycle, commandSuppress, ringSmi;
    logic phase1Go, linkCmdPullup, selectPullup, sharedPin78;
    logic [2:0] stop_clock_count;
    int num_errors = 0, tests_run = 0;
    elsc_ctrl u_elsc_ctrl (.clk_sys, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .at_bus_clock, .select_backoff_in_n, .stop_grant_n, .cpu_address_strobe_n,
        .isaDecoded, .cycleMem(aux), .cycleDma(aux), .cycleIo, .cycleStarted,
        .addrLatchDone(1'b0), .ringIndicatorPin(1'b0), .irq15Slot, .drqUpdated,
        .eoiRequest(1'b0), .readStrobeInt(aux), .rowStrobeInt(aux), .busDirInt,
        .generalIoInt(aux), .speakerInt(1'b0), .speakerSyncSlot(1'b0), .linkCmdOut(),
        .linkCmdPullup, .selectPullup, .general_io_one(), .sharedPin78, .ide_read_strobe_n(),
        .tcPinReadStrobe(), .aleAllowed(), .commandSuppress, .abortCycle, .dmaBlock,
        .eoiBlock(), .irq15Out(), .ringSmi, .speaker_data_out(), .phase1Go, .stop_clock_count,
        .bcastActive, .atClockEnable);
    elsc_link_peer u_elsc_link_peer (.clkRun(atClockEnable), .selReq, .at_bus_clock,
        .select_backoff_in_n);
    always #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Mismatches %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(posedge clk_sys);
        chk(regRdData, exp, msg);
    endtask
    task automatic waitOn(input int sel, input logic lvl, input int lim, input string msg);
        logic v;
        for (int n = 0; n < lim; n++) begin
            @(posedge clk_sys);
            v = sel == 0 ? bcastActive : sel == 1 ? atClockEnable : sel == 2 ? dmaBlock : phase1Go;
            if (v === lvl) break;
        end
        chk({7'h00, v}, {7'h00, lvl}, msg);
    endtask
    // Restart needs select low; it also looks like a backoff, so relatch after
    task automatic restart();
        selReq <= 1'b1;
        waitOn(1, 1'b1, 40, "clock restart");
        selReq <= 1'b0;
        repeat (4) @(posedge clk_sys);
        drqUpdated <= 1'b1;
        @(posedge clk_sys);
        drqUpdated <= 1'b0;
        waitOn(2, 1'b0, 8, "dma free after relatch");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_stops();
        wr(ADDR_CTRL2, 8'hFE);
        waitOn(0, 1'b1, 20, "sw broadcast");
        rdc(ADDR_CTRL2, CTRL2_RESET, "mode reverted, byte ignored");
        chk({5'h00, stop_clock_count}, 8'h01, "count one");
        waitOn(1, 1'b0, 200, "clock gated");
        rdc(ADDR_STATUS, 8'h02, "status stopped");
        restart();
        wr(ADDR_CTRL2, 8'h1D);
        rdc(ADDR_CTRL2, 8'h1D, "ctl2 readback");
        chk({5'h00, stop_clock_count}, 8'h07, "count seven");
        cpu_address_strobe_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({7'h00, phase1Go}, 8'h00, "phase 1 held");
        isaDecoded <= 1'b1;
        waitOn(3, 1'b1, 30, "phase 1 after decode");
        cpu_address_strobe_n <= 1'b1;
        isaDecoded <= 1'b0;
        stop_grant_n <= 1'b0;
        waitOn(0, 1'b1, 20, "hw broadcast");
        waitOn(1, 1'b0, 300, "clock gated");
        stop_grant_n <= 1'b1;
        restart();
        wr(ADDR_CTRL2, 8'h04);
        cpu_address_strobe_n <= 1'b0;
        waitOn(3, 1'b1, 6, "phase 1 at once");
        cpu_address_strobe_n <= 1'b1;
    endtask
    task automatic t_backoff();
        wr(ADDR_CTRL1, 8'hE1);
        aux <= 1'b1;
        cycleIo <= 1'b1;
        cycleStarted <= 1'b1;
        selReq <= 1'b1;
        waitOn(2, 1'b1, 10, "dma blocked");
        chk({6'h00, abortCycle, commandSuppress}, 8'h03, "abort and hide");
        selReq <= 1'b0;
        aux <= 1'b0;
        cycleIo <= 1'b0;
        cycleStarted <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk({7'h00, dmaBlock}, 8'h01, "held until relatch");
        restart();
    endtask
    task automatic t_ring();
        wr(ADDR_CTRL1, 8'h13);
        irq15Slot <= 1'b1;
        busDirInt <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({6'h00, ringSmi, sharedPin78}, 8'h03, "ring smi, dir high");
        irq15Slot <= 1'b0;
        busDirInt <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({6'h00, ringSmi, sharedPin78}, 8'h00, "ring smi, dir low");
    endtask
    task automatic t_off();
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_CTRL2, 8'h02);
        selReq <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk({6'h00, dmaBlock, bcastActive}, 8'h00, "quiet when disabled");
        selReq <= 1'b0;
    endtask
    initial begin
        #200us;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc(ADDR_CTRL1, CTRL1_RESET, "ctl1 reset");
        rdc(ADDR_CTRL2, CTRL2_RESET, "ctl2 reset");
        rdc(8'h10, 8'h00, "unmapped read");
        chk({7'h00, linkCmdPullup}, 8'h01, "pull-up at reset");
        wr(ADDR_CTRL1, 8'h01);
        wr(ADDR_PULLUP_RELEASE, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk({6'h00, linkCmdPullup, selectPullup}, 8'h01, "pull-ups");
        rdc(ADDR_STATUS, 8'h00, "status idle");
        t_stops();
        t_backoff();
        t_ring();
        t_off();
        end_of_test();
    end
endmodule
